// [dsh_top.sv]
// Per-DPLL phase slew limiter and tuning word history delay front end.
//
// The plain strobed port was decided locally.
module dsh_top
  import dsh_pkg::*;
#(
  parameter logic        DPLL_IDX  = 1'b0,         // Instance number.
  parameter int unsigned EIGHTH_MS = 32'(CYC_EIGHTH_MS) // Cycles per 1/8 ms.
)(
  input  wire logic        ref_clk,         // System clock, 250 MHz.
  input  wire logic        rst_b,           // Sync reset, active low.
  input  wire logic [15:0] reg_addr,        // Register byte address.
  input  wire logic [7:0]  reg_wdata,       // Register write data.
  input  wire logic        reg_wr,          // Write strobe.
  input  wire logic        reg_rd,          // Read strobe.
  output logic      [7:0]  reg_rdata,       // Read data, next cycle.
  input  wire logic [39:0] skew_ps,         // Profile phase skew.
  input  wire logic [39:0] hitless_ps,      // Hitless initial correction.
  input  wire logic [39:0] delay_comp_ps,   // Delay compensation.
  input  wire logic [39:0] buildout_ps,     // Phase buildout offset.
  output logic      [39:0] phase_total_ps,  // Offset to phase detector.
  output logic             slew_limiting,   // Limiter is limiting.
  input  wire logic        profile_act,     // Profile became active.
  input  wire logic        phase_lock,      // DPLL phase locked.
  input  wire logic        freq_lock,       // DPLL frequency locked.
  input  wire logic        avg_restart,     // Pause or restart trigger.
  input  wire logic        holdover,        // DPLL is in holdover.
  input  wire logic [45:0] lf_word,         // Loop filter tuning word.
  input  wire logic        lf_valid,        // Loop filter word strobe.
  input  wire logic [45:0] freerun_ftw,     // Freerun tuning word.
  output logic      [45:0] nco_ftw,         // Tuning word to the NCO.
  output dsh_src_e         nco_src,         // Source of nco_ftw.
  output logic             mf_hist_avail,   // Multifunction pin level.
  output logic             mf_hist_upd      // Multifunction pin level.
);
  dsh_core_if lk ();

  // Each instance maps its own address block onto one local map.
  function automatic logic [15:0] norm_addr(input logic [15:0] x,
                                            input logic        i);
    logic [15:0] r;
    r = x;
    if (i) begin
      if (x[15:8] == PG_CFG1)
        r = x - OFS_CFG;
      else if (x[15:8] == PG_LIVE1)
        r = x - OFS_LIVE;
      else if (x == A_IRQ_A + OFS_IRQ || x == A_IRQ_B + OFS_IRQ ||
               x == A_CLR + OFS_IRQ || x == A_CLR_UPD + OFS_IRQ)
        r = x - OFS_IRQ;
      else
        r = A_NONE;
    end
    return r;
  endfunction

  function automatic logic in_rng(input logic [15:0] x,
                                  input logic [15:0] b,
                                  input int unsigned n);
    return (x >= b) && (x < b + 16'(n));
  endfunction

  // Register storage.
  logic [N_SLEW-1:0][7:0] slew_ff;
  logic [N_PHS-1:0][7:0]  phs_ff;
  logic [N_HAT-1:0][7:0]  hat_ff;
  logic [7:0]             ctl_ff;
  logic [7:0]             hold_ff;
  logic [7:0]             rdata_ff;
  logic [7:0]             nxt_rdata;

  // Status and datapath state.
  logic        act_ff;
  logic        dea_ff;
  logic        upd_ff;
  logic        lim_q_ff;
  logic        avail_ff;
  logic [3:0]  sub_ff;
  logic [7:0]  hcnt_ff;
  logic [45:0] hist_ff;
  logic [45:0] samp_ff;
  logic [45:0] lf_last_ff;
  logic [45:0] ftw_ff;
  dsh_src_e    src_ff;
  dsh_state_e  st_ff;
  logic [39:0] ptot_ff;

  logic        nxt_act;
  logic        nxt_dea;
  logic        nxt_upd;
  logic        nxt_avail;
  logic [3:0]  nxt_sub;
  logic [7:0]  nxt_hcnt;
  logic [45:0] nxt_ftw;
  dsh_src_e    nxt_src;
  dsh_state_e  nxt_st;
  logic        rst_tmr;

  // Address decode.
  logic [15:0] a;
  logic [2:0]  bidx;
  logic        wr_slew;
  logic        wr_phs;
  logic        wr_hat;
  logic        wr_ctl;
  logic        wr_hold;
  logic        clr_hit;
  logic        clr_upd_hit;
  logic [7:0]  hat_wv;

  assign a    = norm_addr(reg_addr, DPLL_IDX);
  assign bidx = in_rng(a, A_SLEW, N_SLEW) ? 3'(a - A_SLEW) :
                in_rng(a, A_PHS, N_PHS)   ? 3'(a - A_PHS)  :
                in_rng(a, A_HAT, N_HAT)   ? 3'(a - A_HAT)  :
                                            3'(a - A_HIST);
  assign wr_slew = reg_wr && in_rng(a, A_SLEW, N_SLEW);
  assign wr_phs  = reg_wr && in_rng(a, A_PHS, N_PHS);
  assign wr_hat  = reg_wr && in_rng(a, A_HAT, N_HAT);
  assign wr_ctl  = reg_wr && a == A_CTL;
  assign wr_hold = reg_wr && a == A_HOLD;
  assign clr_hit     = reg_wr && a == A_CLR;
  assign clr_upd_hit = reg_wr && a == A_CLR_UPD;
  // The window field is 28 bits; its top nibble always reads zero.
  assign hat_wv = (bidx == 3'(N_HAT - 1)) ? {4'h0, reg_wdata[3:0]}
                                           : reg_wdata;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      slew_ff <= RST_SLEW;
      phs_ff  <= '0;
      hat_ff  <= RST_HAT;
      ctl_ff  <= RST_CTL;
      hold_ff <= RST_HOLD;
    end else begin
      if (wr_slew)
        slew_ff[bidx] <= reg_wdata;
      if (wr_phs)
        phs_ff[bidx] <= reg_wdata;
      if (wr_hat)
        hat_ff[bidx] <= hat_wv;
      if (wr_ctl)
        ctl_ff <= reg_wdata;
      if (wr_hold)
        hold_ff <= reg_wdata;
    end
  end

  // Limiter: only the covered sources pass through the ramp.
  assign lk.rate   = slew_ff;
  assign lk.target = phs_ff + skew_ps + hitless_ps;
  assign lk.hat    = {hat_ff[3][3:0], hat_ff[2], hat_ff[1], hat_ff[0]};

  dsh_slew_limiter u_lim (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .lk      (lk)
  );

  dsh_eighth_timer #(
    .CYC (15'(EIGHTH_MS))
  ) u_tmr (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tk      (lk)
  );

  // Limiter flags: a new edge wins over a clear in the same cycle.
  logic lim_rise;
  logic lim_fall;
  assign lim_rise = lk.limiting && !lim_q_ff;
  assign lim_fall = !lk.limiting && lim_q_ff;
  assign nxt_act = lim_rise ||
                   (act_ff && !(clr_hit && reg_wdata[B_LACT]));
  assign nxt_dea = lim_fall ||
                   (dea_ff && !(clr_hit && reg_wdata[B_LDEA]));

  // History start delay.
  logic hat0;
  logic evt_ok;
  logic timed;
  logic run;
  logic sub_tick;
  logic [3:0] sub_inc;
  logic [3:0] need;
  assign hat0   = lk.hat == 28'h0;
  assign evt_ok = (!ctl_ff[B_DPH] || phase_lock) &&
                  (!ctl_ff[B_DFR] || freq_lock) &&
                  (!ctl_ff[B_DSL] || !lk.limiting);
  assign timed  = (hold_ff != 8'h00) && !hat0;
  assign run    = st_ff == ST_RUN;

  always_comb begin
    nxt_st   = st_ff;
    nxt_hcnt = hcnt_ff;
    rst_tmr  = 1'b0;
    if (profile_act) begin
      nxt_st  = ST_WAIT;
      rst_tmr = 1'b1;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_st = ST_IDLE;
        end
        ST_WAIT: begin
          if (evt_ok) begin
            rst_tmr  = 1'b1;
            nxt_st   = timed ? ST_HOLD : ST_RUN;
            nxt_hcnt = hold_ff;
          end
        end
        ST_HOLD: begin
          if (hat0) begin
            nxt_st = ST_RUN;
          end else if (lk.tick) begin
            if (hcnt_ff <= 8'h01) begin
              nxt_st  = ST_RUN;
              rst_tmr = 1'b1;
            end else begin
              nxt_hcnt = hcnt_ff - 8'h01;
            end
          end
        end
        ST_RUN: begin
          // Averaging never stops for a status condition falling.
          if (avg_restart) begin
            rst_tmr  = 1'b1;
            nxt_st   = timed ? ST_HOLD : ST_RUN;
            nxt_hcnt = hold_ff;
          end
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end
  assign lk.restart = rst_tmr;

  // Averaging front end: subinterval count and availability.
  assign sub_tick  = run && lk.tick && !hat0 && !profile_act;
  assign sub_inc   = (sub_ff == SUB_FULL) ? SUB_FULL : sub_ff + 4'h1;
  assign need      = ctl_ff[B_QUICK] ? SUB_QUICK : SUB_FULL;
  assign nxt_sub   = profile_act ? 4'h0 : sub_tick ? sub_inc : sub_ff;
  assign nxt_avail = (hat0 || profile_act) ? 1'b0 :
                     (sub_tick && sub_inc >= need) ? 1'b1 : avail_ff;
  assign nxt_upd   = (sub_tick && nxt_avail) ||
                     (upd_ff && !(clr_upd_hit && reg_wdata[B_UPD]));

  // Holdover word selection.
  assign nxt_src = !holdover      ? SRC_LOOP :
                   avail_ff       ? SRC_HIST :
                   ctl_ff[B_SGL]  ? SRC_LOOP : SRC_FREE;
  assign nxt_ftw = (nxt_src == SRC_HIST) ? hist_ff :
                   (nxt_src == SRC_LOOP) ? lf_last_ff : freerun_ftw;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_ff    <= ST_IDLE;
      hcnt_ff  <= 8'h00;
      sub_ff   <= 4'h0;
      avail_ff <= 1'b0;
      upd_ff   <= 1'b0;
      act_ff   <= 1'b0;
      dea_ff   <= 1'b0;
      lim_q_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      hcnt_ff  <= nxt_hcnt;
      sub_ff   <= nxt_sub;
      avail_ff <= nxt_avail;
      upd_ff   <= nxt_upd;
      act_ff   <= nxt_act;
      dea_ff   <= nxt_dea;
      lim_q_ff <= lk.limiting;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hist_ff    <= '0;
      samp_ff    <= '0;
      lf_last_ff <= '0;
      ftw_ff     <= '0;
      src_ff     <= SRC_FREE;
      ptot_ff    <= '0;
    end else begin
      if (lf_valid)
        lf_last_ff <= lf_word;
      if (run && lf_valid)
        samp_ff <= lf_word;
      if (run && hat0 && lf_valid)
        hist_ff <= lf_word;
      else if (sub_tick && nxt_avail)
        hist_ff <= samp_ff;
      ftw_ff  <= nxt_ftw;
      src_ff  <= nxt_src;
      ptot_ff <= lk.phase + delay_comp_ps + buildout_ps;
    end
  end

  // Read side.
  logic [N_HIST-1:0][7:0] hist_b;
  logic [7:0] irq_a_v;
  logic [7:0] irq_b_v;
  logic [7:0] live_v;
  assign hist_b = {2'b00, hist_ff};
  always_comb begin
    irq_a_v         = 8'h00;
    irq_a_v[B_LACT] = act_ff;
    irq_a_v[B_LDEA] = dea_ff;
    irq_b_v         = 8'h00;
    irq_b_v[B_UPD]  = upd_ff;
    live_v          = 8'h00;
    live_v[B_AVAIL] = avail_ff;
  end
  assign nxt_rdata =
    !reg_rd                    ? 8'h00 :
    in_rng(a, A_SLEW, N_SLEW)  ? slew_ff[bidx] :
    in_rng(a, A_PHS, N_PHS)    ? phs_ff[bidx] :
    in_rng(a, A_HAT, N_HAT)    ? hat_ff[bidx] :
    in_rng(a, A_HIST, N_HIST)  ? hist_b[bidx] :
    a == A_CTL                 ? ctl_ff :
    a == A_HOLD                ? hold_ff :
    a == A_IRQ_A               ? irq_a_v :
    a == A_IRQ_B               ? irq_b_v :
    a == A_LIVE                ? live_v : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata      = rdata_ff;
  assign phase_total_ps = ptot_ff;
  assign slew_limiting  = lk.limiting;
  assign nco_ftw        = ftw_ff;
  assign nco_src        = src_ff;
  assign mf_hist_avail  = avail_ff;
  assign mf_hist_upd    = upd_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_act_latch: assert property ($rose(lk.limiting) |=> act_ff)
    else $error("activated flag missed a limiter rise");
  a_deact_latch: assert property ($fell(lk.limiting) |=> dea_ff)
    else $error("deactivated flag missed a limiter fall");
  a_flag_sticky: assert property (act_ff && dea_ff && !clr_hit
    |=> act_ff && dea_ff)
    else $error("limiter flag dropped without a clear");
  a_word_discard: assert property (!run && lf_valid
    |=> $stable(samp_ff))
    else $error("word taken while delay pending");
  a_event_gate: assert property (st_ff == ST_WAIT && !evt_ok && !profile_act
    |=> st_ff == ST_WAIT)
    else $error("averaging left wait with a condition false");
  a_run_holds: assert property (run && !profile_act && !avg_restart
    |=> run)
    else $error("averaging stopped without a trigger");
  a_profile_clear: assert property (profile_act
    |=> !avail_ff && st_ff == ST_WAIT && sub_ff == 4'h0)
    else $error("profile activation did not reset averaging");
  a_bypass_avail: assert property (hat0 |=> !avail_ff)
    else $error("history available with zero window");
  a_holdover_pick: assert property (holdover && avail_ff
    |=> nco_src == SRC_HIST && nco_ftw == $past(hist_ff))
    else $error("holdover did not use history");

  c_lim_rise: cover property ($rose(lk.limiting));
  c_hold_run: cover property (st_ff == ST_HOLD ##1 st_ff == ST_RUN);
  c_avail_set: cover property ($rose(avail_ff));
endmodule // dsh_top

// [dsh_pkg.sv]
// Shared constants and types for the DPLL slew limiter and history delay.
package dsh_pkg;
  // Register byte addresses of the first DPLL instance.
  localparam logic [15:0] A_HAT     = 16'h100A;
  localparam logic [15:0] A_CTL     = 16'h100E;
  localparam logic [15:0] A_HOLD    = 16'h1010;
  localparam logic [15:0] A_SLEW    = 16'h1011;
  localparam logic [15:0] A_PHS     = 16'h1015;
  localparam logic [15:0] A_CLR     = 16'h200B;
  localparam logic [15:0] A_CLR_UPD = 16'h200C;
  localparam logic [15:0] A_IRQ_A   = 16'h3010;
  localparam logic [15:0] A_IRQ_B   = 16'h3011;
  localparam logic [15:0] A_LIVE    = 16'h3102;
  localparam logic [15:0] A_HIST    = 16'h3103;
  localparam logic [15:0] A_NONE    = 16'hFFFF;
  // Address shifts and pages of the second instance.
  localparam logic [15:0] OFS_CFG   = 16'h0400;
  localparam logic [15:0] OFS_LIVE  = 16'h0100;
  localparam logic [15:0] OFS_IRQ   = 16'h0005;
  localparam logic [7:0]  PG_CFG1   = 8'h14;
  localparam logic [7:0]  PG_LIVE1  = 8'h32;
  // Field byte counts.
  localparam int unsigned N_HAT  = 4;
  localparam int unsigned N_SLEW = 4;
  localparam int unsigned N_PHS  = 5;
  localparam int unsigned N_HIST = 6;
  // Bit positions.
  localparam int unsigned B_SGL   = 1;
  localparam int unsigned B_QUICK = 2;
  localparam int unsigned B_DPH   = 3;
  localparam int unsigned B_DFR   = 4;
  localparam int unsigned B_DSL   = 5;
  localparam int unsigned B_LACT  = 4;
  localparam int unsigned B_LDEA  = 5;
  localparam int unsigned B_UPD   = 2;
  localparam int unsigned B_AVAIL = 0;
  // Reset values and subinterval counts.
  localparam logic [31:0] RST_SLEW = 32'h0600_0000;
  localparam logic [31:0] RST_HAT  = 32'h0000_000A;
  localparam logic [7:0]  RST_CTL  = 8'h00;
  localparam logic [7:0]  RST_HOLD = 8'h00;
  localparam logic [3:0]  SUB_FULL  = 4'h8;
  localparam logic [3:0]  SUB_QUICK = 4'h2;
  // Timing: clock period and millisecond in picoseconds.
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint MS_PS         = 1000000000;
  localparam longint S_PS          = 64'h0000_00E8_D4A5_1000;
  localparam longint CYC_EIGHTH_MS = MS_PS / (8 * CLK_PERIOD_PS);
  // Step per cycle in 2^-40 ps per unit of rate, rounded down.
  localparam logic [12:0] SLEW_K =
    13'((longint'(1) <<< 40) * CLK_PERIOD_PS / S_PS);
  typedef enum logic [1:0] {
    SRC_FREE = 2'h0,
    SRC_LOOP = 2'h1,
    SRC_HIST = 2'h2
  } dsh_src_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_HOLD = 2'h3,
    ST_RUN  = 2'h2
  } dsh_state_e;
endpackage

// [dsh_core_if.sv]
// Carrier between the top and its limiter and eighth-window timer.
interface dsh_core_if;
  logic [31:0] rate;
  logic [39:0] target;
  logic [39:0] phase;
  logic        limiting;
  logic [27:0] hat;
  logic        restart;
  logic        tick;
  modport top (output rate, target, hat, restart,
               input phase, limiting, tick);
  modport lim (input rate, target, output phase, limiting);
  modport tmr (input hat, restart, output tick);
endinterface

// [dsh_slew_limiter.sv]
// Phase slew rate limiter: turns target steps into bounded ramps.
module dsh_slew_limiter
  import dsh_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic rst_b,   // Synchronous reset, active low.
  dsh_core_if.lim  lk       // Rate and target in, ramp out.
);
  logic signed [81:0] pos_ff;
  logic signed [81:0] nxt_pos;
  logic signed [81:0] tgt;
  logic signed [81:0] diff;
  logic signed [81:0] mag;
  logic signed [81:0] mv;
  logic signed [81:0] amv;
  logic [44:0]        step;
  logic               lim_ff;
  logic               nxt_lim;

  // Position is kept in 2^-40 ps so small rates still move.
  assign step = 45'(lk.rate) * 45'(SLEW_K);
  assign tgt  = {{2{lk.target[39]}}, lk.target, 40'h00_0000_0000};
  assign diff = tgt - pos_ff;
  assign mag  = diff[81] ? -diff : diff;
  assign nxt_lim = (lk.rate != 32'h0) &&
                   (mag > $signed({37'h0, step}));
  // Step rounding is down, so the slope never exceeds the limit.
  assign nxt_pos = !nxt_lim ? tgt :
                   diff[81] ? pos_ff - $signed({37'h0, step}) :
                              pos_ff + $signed({37'h0, step});
  assign mv  = nxt_pos - pos_ff;
  assign amv = mv[81] ? -mv : mv;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pos_ff <= '0;
      lim_ff <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
      lim_ff <= nxt_lim;
    end
  end

  assign lk.phase    = pos_ff[79:40];
  assign lk.limiting = lim_ff;

  a_ramp_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (lk.rate != 32'h0) |-> (amv <= $signed({37'h0, step})))
    else $error("ramp step above slew limit");
  a_zero_rate_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (lk.rate == 32'h0) |=> !lim_ff && (pos_ff == $past(tgt)))
    else $error("limiter active with zero rate");
endmodule // dsh_slew_limiter

// [dsh_eighth_timer.sv]
// Timer that ticks once per eighth of the accumulation window.
module dsh_eighth_timer
  import dsh_pkg::*;
#(
  parameter logic [14:0] CYC = 15'(CYC_EIGHTH_MS) // Cycles per 1/8 ms.
)(
  input wire logic ref_clk, // System clock.
  input wire logic rst_b,   // Synchronous reset, active low.
  dsh_core_if.tmr  tk       // Window length, restart, tick.
);
  logic [42:0] cnt_ff;
  logic [42:0] nxt_cnt;
  logic [42:0] span;
  logic [42:0] cnt_inc;
  logic        tick_ff;
  logic        nxt_tick;

  assign span    = 43'(tk.hat) * 43'(CYC);
  assign cnt_inc = cnt_ff + 43'h1;
  // A shortened window ends the current interval at once.
  assign nxt_tick = !tk.restart && (tk.hat != 28'h0) && (cnt_inc >= span);
  assign nxt_cnt  = (tk.restart || nxt_tick || tk.hat == 28'h0) ?
                    43'h0 : cnt_inc;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_ff  <= 43'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;
endmodule // dsh_eighth_timer

// [tb.sv]
// Self-checking testbench for the slew limiter and history delay block.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dsh_pkg::*;
  logic        ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_p = 0;
  logic        profile_act = 0, phase_lock = 0, freq_lock = 0, feed = 0;
  logic        avg_restart = 0, holdover = 0, lf_valid = 0;
  logic        slew_limiting, mf_hist_avail, mf_hist_upd;
  logic [15:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata;
  logic [39:0] skew_ps = 0, hitless_ps = 0, buildout_ps = 0;
  logic [39:0] delay_comp_ps = 0, phase_total_ps;
  logic [45:0] lf_word = 0, freerun_ftw = 0, nco_ftw;
  dsh_src_e    nco_src;
  logic [7:0]  q[$];
  int          n_fail = 0, n_compared = 0, i;

  dsh_top #(.EIGHTH_MS(4)) dsh_top_i (.ref_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .skew_ps, .hitless_ps,
    .delay_comp_ps, .buildout_ps, .phase_total_ps, .slew_limiting,
    .profile_act, .phase_lock, .freq_lock, .avg_restart, .holdover,
    .lf_word, .lf_valid, .freerun_ftw, .nco_ftw, .nco_src,
    .mf_hist_avail, .mf_hist_upd);

  always #2 ref_clk = ~ref_clk;

  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Compares the phase handed to the detector.
  task automatic chk_ph(input string n, input logic [39:0] e);
    chk(n, {24'h0, e}, {24'h0, phase_total_ps});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe.
  always @(posedge ref_clk) begin
    if (rd_p) begin
      chk("reg_rdata", q.pop_front(), reg_rdata);
    end
    rd_p <= reg_rd;
  end

  // Loop filter feed; when stopped the last word stays on lf_word.
  always @(posedge ref_clk) begin
    lf_valid <= feed;
    if (feed) begin
      lf_word <= 46'({$urandom, $urandom});
    end
  end

  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic pulse_profile;
    @(posedge ref_clk);
    profile_act <= 1'b1;
    @(posedge ref_clk);
    profile_act <= 1'b0;
  endtask

  initial begin
    i = $urandom(32'h5F2DE328);
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    delay_comp_ps <= {8'h00, $urandom};
    buildout_ps <= {8'h00, $urandom};
    freerun_ftw <= 46'({$urandom, $urandom});
    for (i = 0; i < 4; i++) rd(A_SLEW + 16'(i), 8'(RST_SLEW >> 8 * i));
    rd(A_CTL, 8'h00);
    rd(A_HOLD, 8'h00);
    rd(A_NONE, 8'h00);
    rd(A_CLR, 8'h00);
    rd(A_IRQ_A, 8'h00);
    repeat (3) @(posedge ref_clk);
    // Offsets outside the limiter must arrive whole, at once.
    chk_ph("comp_only", delay_comp_ps + buildout_ps);
    buildout_ps <= '0;
    // Default rate moves far less than a picosecond per cycle.
    wr(A_PHS, 8'h80);
    for (i = 0; i < 20 && slew_limiting !== 1'b1; i++) @(posedge ref_clk);
    chk("limiting_on", 1, slew_limiting);
    rd(A_IRQ_A, 8'h10);
    for (i = 0; i < 4; i++) wr(A_SLEW + 16'(i), 8'hFF);
    for (i = 0; i < 50 && slew_limiting !== 1'b0; i++) @(posedge ref_clk);
    chk("limiting_off", 0, slew_limiting);
    repeat (3) @(posedge ref_clk);
    chk_ph("ramp_end", delay_comp_ps + 40'h80);
    rd(A_IRQ_A, 8'h30);
    wr(A_CLR, 8'h30);
    rd(A_IRQ_A, 8'h00);
    for (i = 0; i < 4; i++) wr(A_SLEW + 16'(i), 8'h00);
    wr(A_PHS, 8'h40);
    repeat (4) @(posedge ref_clk);
    chk_ph("rate_zero", delay_comp_ps + 40'h40);
    rd(A_IRQ_A, 8'h00);
    // Back to the slow default rate: skew and hitless steps must ramp.
    wr(A_SLEW + 16'h0003, 8'h06);
    skew_ps <= 40'h20;
    hitless_ps <= 40'h20;
    repeat (3) @(posedge ref_clk);
    chk("skew_lim", 1, slew_limiting);
    wr(A_CTL, 8'h18);
    wr(A_HOLD, 8'h01);
    phase_lock <= 1'b1;
    feed <= 1'b1;
    pulse_profile();
    repeat (200) @(posedge ref_clk);
    chk("avail_wait", 0, mf_hist_avail);
    holdover <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("src_free", SRC_FREE, nco_src);
    chk("ftw_free", freerun_ftw, nco_ftw);
    wr(A_CTL, 8'h1A);
    repeat (3) @(posedge ref_clk);
    chk("src_loop", SRC_LOOP, nco_src);
    holdover <= 1'b0;
    freq_lock <= 1'b1;
    repeat (300) @(posedge ref_clk);
    chk("avail_hold", 0, mf_hist_avail);
    for (i = 0; i < 400 && mf_hist_avail !== 1'b1; i++) @(posedge ref_clk);
    chk("avail_set", 1, mf_hist_avail);
    freq_lock <= 1'b0;
    repeat (50) @(posedge ref_clk);
    chk("avail_kept", 1, mf_hist_avail);
    chk("upd_pin", 1, mf_hist_upd);
    holdover <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("src_hist", SRC_HIST, nco_src);
    rd(A_LIVE, 8'h01);
    rd(A_IRQ_B, 8'h04);
    // A restart reruns the one-eighth hold-off before updates resume.
    @(posedge ref_clk) avg_restart <= 1'b1;
    @(posedge ref_clk) avg_restart <= 1'b0;
    wr(A_CLR_UPD, 8'h04);
    repeat (50) @(posedge ref_clk);
    chk("upd_held", 0, mf_hist_upd);
    chk("avail_restart", 1, mf_hist_avail);
    for (i = 0; i < 60 && mf_hist_upd !== 1'b1; i++) @(posedge ref_clk);
    chk("upd_again", 1, mf_hist_upd);
    holdover <= 1'b0;
    wr(A_CTL, 8'h00);
    pulse_profile();
    repeat (3) @(posedge ref_clk);
    chk("avail_clear", 0, mf_hist_avail);
    for (i = 0; i < 4; i++) wr(A_HAT + 16'(i), 8'h00);
    feed <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (i = 0; i < 6; i++) rd(A_HIST + 16'(i), 8'(lf_word >> 8 * i));
    rd(A_LIVE, 8'h00);
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule // tb
